// ---- rtl/ext_overtemp_defines.vh ----
// register offsets, field positions and constants of the external temperature path
`ifndef EXT_OVERTEMP_DEFINES_VH
`define EXT_OVERTEMP_DEFINES_VH
// register offsets (byte addresses on the plain port)
`define ADDR_SHUTDOWN_LOW_CLAMP   8'h5a
`define ADDR_DIM_POINT_HIGH_CLAMP 8'h5b
`define ADDR_CAL_SENSE_DELAY      8'h5c
`define ADDR_IRQ_STATUS           8'h5d
`define ADDR_IRQ_MASK             8'h5e
`define ADDR_LIVE_STATUS          8'h5f
// reset values
`define RST_SHUTDOWN_LOW_CLAMP    8'h00
`define RST_DIM_POINT_HIGH_CLAMP  8'h00
`define RST_CAL_SENSE_DELAY       8'h00
// writable bits of the sense delay register (reserved bits read zero)
`define CAL_SENSE_WMASK           8'h5c
// field positions
`define TRIP_OFS_MSB  7
`define TRIP_OFS_LSB  4
`define LOW_SEL_MSB   3
`define LOW_SEL_LSB   1
`define DIM_EN_BIT    0
`define DIM_START_MSB 7
`define DIM_START_LSB 3
`define HIGH_SEL_MSB  2
`define HIGH_SEL_LSB  0
`define LINE_CAL_BIT  6
`define DELAY_MSB     4
`define DELAY_LSB     2
// threshold arithmetic
`define TRIP_STEP     10'd4
`define LOW_STEP      10'd5
`define DIM_BASE      10'd80
`define DIM_STEP      10'd4
`define HIGH_BASE     10'd80
`define HIGH_STEP     10'd20
`define CODE_MAX      10'd255
// compensation delay step
`define DELAY_STEP_NS 50
`define CLK_PERIOD_NS 10
`define DELAY_STEP_CYC ((`DELAY_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// interrupt status bits
`define IRQ_TRIP_SET   0
`define IRQ_TRIP_CLR   1
`define IRQ_DIM_START  2
`endif

// ---- rtl/code_clamp.v ----
// clamps an 8-bit temperature code between a lower and an upper limit
module code_clamp (
  // code and limits
  input  wire [7:0] code_in,
  input  wire [7:0] low_lim,
  input  wire [7:0] high_lim,
  // clamped code
  output wire [7:0] code_out
);
  // lower limit checked first, so codes below it get it even if limits cross
  assign code_out = (code_in < low_lim)  ? low_lim :
                    (code_in > high_lim) ? high_lim : code_in;
endmodule // code_clamp

// ---- rtl/ext_overtemp_code_config.v ----
// configuration and threshold logic of the external thermistor temperature path
//
// Overview of operation
// - trip code is resume code plus 4*offset
// - fast code above trip code shuts output
// - color code lower limit is (sel+1)*5
// - dim enable bit gates temperature dimming
// - dim start code is 80 plus 4*field
// - upper limit: 0 trip code, else 100..220
// - line calibration enabled when bit is zero
// - sense delay compensation is field times 50ns
// - fast filter feeds trip check and color
// - slow filter feeds dimming with temperature
`include "ext_overtemp_defines.vh"
module ext_overtemp_code_config #(
  parameter DELAY_STEP_CYCLES = `DELAY_STEP_CYC  // cycles per 50 ns step
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // temperature codes from filters
  input  wire [7:0] resume_temp_code,
  input  wire [7:0] fast_code,
  input  wire [7:0] slow_code,
  // thresholds and status
  output reg  [7:0] trip_temp_code,
  output reg  [7:0] dim_start_temp_code,
  output reg  [7:0] color_code,
  output reg        overtemp_shutdown,
  output reg        temp_dim_active,
  output reg        line_cal_enable,
  // sense delay compensation
  output reg  [2:0] switch_time_comp,
  output reg  [5:0] switch_time_cycles,
  // interrupt
  output reg        irq
);

  // configuration registers
  reg  [7:0] shutdown_and_low_clamp_config;
  reg  [7:0] dim_point_and_high_clamp_config;
  reg  [7:0] calibration_and_sense_delay_config;
  reg  [2:0] irq_status;   // sticky events
  reg  [2:0] irq_mask;     // one enables
  reg        trip_prev;    // previous trip state for edges
  reg        dim_prev;     // previous dim state for edges

  // field views
  wire [3:0] trip_offset_field = shutdown_and_low_clamp_config[`TRIP_OFS_MSB:`TRIP_OFS_LSB];
  wire [2:0] lower_clamp_sel   = shutdown_and_low_clamp_config[`LOW_SEL_MSB:`LOW_SEL_LSB];
  wire       dim_enable        = shutdown_and_low_clamp_config[`DIM_EN_BIT];
  wire [4:0] dim_start_field   = dim_point_and_high_clamp_config[`DIM_START_MSB:`DIM_START_LSB];
  wire [2:0] upper_clamp_sel   = dim_point_and_high_clamp_config[`HIGH_SEL_MSB:`HIGH_SEL_LSB];
  wire       line_cal_disable  = calibration_and_sense_delay_config[`LINE_CAL_BIT];
  wire [2:0] delay_field       = calibration_and_sense_delay_config[`DELAY_MSB:`DELAY_LSB];

  // saturate a 10-bit sum to an 8-bit code
  function [7:0] sat8;
    input [9:0] sum;
    begin
      sat8 = (sum > `CODE_MAX) ? 8'hff : sum[7:0];
    end
  endfunction

  // derived thresholds, combinational
  wire [7:0] next_trip   = sat8({2'b00, resume_temp_code} +
                                `TRIP_STEP * {6'd0, trip_offset_field});
  wire [7:0] next_dim    = sat8(`DIM_BASE + `DIM_STEP * {5'd0, dim_start_field});
  wire [7:0] low_lim     = sat8(`LOW_STEP * ({7'd0, lower_clamp_sel} + 10'd1));
  // zero selects the trip code, others step by 20 from 100
  wire [7:0] high_lim    = (upper_clamp_sel == 3'd0) ? next_trip :
                           sat8(`HIGH_BASE + `HIGH_STEP * {7'd0, upper_clamp_sel});
  wire [7:0] clamped;    // fast code clamped for color use
  wire       next_trip_hit = fast_code > next_trip;
  wire       next_dim_hit  = dim_enable && (slow_code > next_dim);

  // color code limiter
  code_clamp u_clamp (
    .code_in  (fast_code),
    .low_lim  (low_lim),
    .high_lim (high_lim),
    .code_out (clamped)
  );

  // compensation delay in cycles, 0..350 ns
  wire [9:0] delay_cyc = {7'd0, delay_field} * DELAY_STEP_CYCLES[9:0];

  // register writes, status and outputs
  always @(posedge clk) begin
    if (rst) begin
      shutdown_and_low_clamp_config      <= `RST_SHUTDOWN_LOW_CLAMP;
      dim_point_and_high_clamp_config    <= `RST_DIM_POINT_HIGH_CLAMP;
      calibration_and_sense_delay_config <= `RST_CAL_SENSE_DELAY;
      irq_status          <= 3'h0;
      irq_mask            <= 3'h0;
      trip_prev           <= 1'b0;
      dim_prev            <= 1'b0;
      trip_temp_code      <= 8'h00;
      dim_start_temp_code <= 8'h00;
      color_code          <= 8'h00;
      overtemp_shutdown   <= 1'b0;
      temp_dim_active     <= 1'b0;
      line_cal_enable     <= 1'b0;
      switch_time_comp    <= 3'h0;
      switch_time_cycles  <= 6'h00;
      irq                 <= 1'b0;
    end else begin
      // configuration writes
      if (wr && addr == `ADDR_SHUTDOWN_LOW_CLAMP)
        shutdown_and_low_clamp_config <= wdata;
      if (wr && addr == `ADDR_DIM_POINT_HIGH_CLAMP)
        dim_point_and_high_clamp_config <= wdata;
      if (wr && addr == `ADDR_CAL_SENSE_DELAY)
        calibration_and_sense_delay_config <= wdata & `CAL_SENSE_WMASK;
      if (wr && addr == `ADDR_IRQ_MASK)
        irq_mask <= wdata[2:0];
      // sticky events: a set in the same cycle wins over write-one clear
      irq_status <= (irq_status & ~((wr && addr == `ADDR_IRQ_STATUS) ? wdata[2:0] : 3'h0))
                    | {next_dim_hit & ~dim_prev,
                       ~next_trip_hit & trip_prev,
                       next_trip_hit & ~trip_prev};
      trip_prev           <= next_trip_hit;
      dim_prev            <= next_dim_hit;
      // registered outputs
      trip_temp_code      <= next_trip;
      dim_start_temp_code <= next_dim;
      color_code          <= clamped;
      overtemp_shutdown   <= next_trip_hit;
      temp_dim_active     <= next_dim_hit;
      line_cal_enable     <= ~line_cal_disable;
      switch_time_comp    <= delay_field;
      switch_time_cycles  <= delay_cyc[5:0];
      irq                 <= |(irq_status & irq_mask);
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_SHUTDOWN_LOW_CLAMP:   rdata <= shutdown_and_low_clamp_config;
        `ADDR_DIM_POINT_HIGH_CLAMP: rdata <= dim_point_and_high_clamp_config;
        `ADDR_CAL_SENSE_DELAY:      rdata <= calibration_and_sense_delay_config;
        `ADDR_IRQ_STATUS:           rdata <= {5'd0, irq_status};
        `ADDR_IRQ_MASK:             rdata <= {5'd0, irq_mask};
        `ADDR_LIVE_STATUS:          rdata <= {6'd0, temp_dim_active, overtemp_shutdown};
        default:                    rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;  // data stands only in the cycle after the read
    end
  end

endmodule // ext_overtemp_code_config

// ---- bench/ext_overtemp_code_config_properties.sv ----
// port assertions for the external temperature threshold block
module ext_overtemp_checker #(parameter DELAY_STEP_CYCLES = 5) (
  // clock, reset, register port
  input wire logic       clk, rst, wr, rd,
  input wire logic [7:0] addr, wdata, rdata,
  // codes in and out
  input wire logic [7:0] resume_temp_code, fast_code, slow_code,
  input wire logic [7:0] trip_temp_code, dim_start_temp_code, color_code,
  input wire logic       overtemp_shutdown, temp_dim_active, line_cal_enable,
  input wire logic [2:0] switch_time_comp,
  input wire logic [5:0] switch_time_cycles,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // outputs lag their causes by one cycle, so first look two edges after reset
  a_trip_level: assert property (!$past(rst) && !$past(rst,2) |->
    overtemp_shutdown == ($past(fast_code) > trip_temp_code)) else $error("shutdown level wrong");
  a_trip_floor: assert property (!$past(rst) && !$past(rst,2) |->
    trip_temp_code >= $past(resume_temp_code)) else $error("trip code below resume code");
  a_color_floor: assert property (!$past(rst) && !$past(rst,2) |->
    color_code >= 8'h05) else $error("color code under lowest clamp");
  a_dim_gate: assert property (temp_dim_active |->
    $past(slow_code) > dim_start_temp_code) else $error("dimming active below start");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  a_dim_start: assert property (wr && addr == 8'h5b |-> ##2
    dim_start_temp_code == 8'd80 + {$past(wdata[7:3],2), 2'b00}) else $error("dim start wrong");
  a_line_cal: assert property (wr && addr == 8'h5c |-> ##2
    line_cal_enable == !$past(wdata[6],2)) else $error("line calibration enable wrong");
  a_comp_field: assert property (wr && addr == 8'h5c |-> ##2
    switch_time_comp == $past(wdata[4:2],2)) else $error("delay field wrong");
  a_comp_cycles: assert property (
    switch_time_cycles == 6'(switch_time_comp * DELAY_STEP_CYCLES)) else $error("delay cycles");
  // status and mask are cleared by reset, so the line must be low right after it
  a_irq_after_reset: assert property ($past(rst) |-> !irq) else $error("irq high after reset");
endmodule // ext_overtemp_checker
bind ext_overtemp_code_config ext_overtemp_checker #(.DELAY_STEP_CYCLES(DELAY_STEP_CYCLES)) u_chk (.*);

// ---- bench/thermistor_model.sv ----
// converter and filter stand-in feeding temperature codes
module thermistor_model (
  input  wire logic       clk,
  input  wire logic [7:0] temp_set, wake_set,
  output logic      [7:0] fast_code, slow_code, resume_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // slow path lags the fast one by a stage, like the longer filter
  always @(posedge clk) begin
    fast_code   <= temp_set;
    slow_code   <= fast_code;
    resume_code <= wake_set;
  end
endmodule // thermistor_model

// ---- bench/tb.sv ----
// self-checking bench for the temperature threshold block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] addr = 0, wdata = 0, tset = 0, wset = 0, a, b, c;
  wire [7:0] rdata, rc, fc, sc, trip, dimc, col;
  wire [2:0] comp;
  wire [5:0] cyc;
  wire ovt, dact, lce, irq;
  int miscompares = 0, checks_done = 0, tr, hi, cl, ds;
  initial forever #5 clk = ~clk;
  thermistor_model u_thermistor_model (.clk(clk), .temp_set(tset), .wake_set(wset),
    .fast_code(fc), .slow_code(sc), .resume_code(rc));
  ext_overtemp_code_config #(.DELAY_STEP_CYCLES(5)) u_ext_overtemp_code_config (.clk(clk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .resume_temp_code(rc), .fast_code(fc), .slow_code(sc), .trip_temp_code(trip),
    .dim_start_temp_code(dimc), .color_code(col), .overtemp_shutdown(ovt),
    .temp_dim_active(dact), .line_cal_enable(lce), .switch_time_comp(comp),
    .switch_time_cycles(cyc), .irq(irq));
  // one compare against the bench model
  task chk(input logic [7:0] got, input int exp);
    checks_done++;
    if (got !== 8'(exp)) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] ad, d);
    @(posedge clk);
    wr <= 1; addr <= ad; wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task rchk(input logic [7:0] ad, input int e);
    @(posedge clk);
    rd <= 1; addr <= ad;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000 miscompares++;
    wrap_up;
  end
  initial begin
    tr = $urandom(32'hf49eac98);
    repeat (4) @(posedge clk);
    rst <= 0;
    rchk(8'h5a, 0); rchk(8'h5b, 0); rchk(8'h5c, 0); rchk(8'h00, 0);
    $display("reset and unmapped reads done");
    // every upper clamp select three times, random fields and codes
    for (int i = 0; i < 24; i++) begin
      @(posedge clk) begin wset <= $urandom; tset <= $urandom; end
      a = $urandom; b = $urandom; c = $urandom; b[2:0] = i[2:0];
      wreg(8'h5a, a); wreg(8'h5b, b); wreg(8'h5c, c);
      repeat (4) @(posedge clk);
      #1 tr = wset + 4 * a[7:4];
      if (tr > 255) tr = 255;
      ds = 80 + 4 * b[7:3];
      hi = (b[2:0] == 0) ? tr : 80 + 20 * b[2:0];
      cl = (tset > hi) ? hi : tset;
      if (cl < (a[3:1] + 1) * 5) cl = (a[3:1] + 1) * 5;
      chk(trip, tr);
      chk(dimc, ds);
      chk(col, cl);
      chk(ovt, tset > tr);
      chk(dact, a[0] && tset > ds);
      chk(lce, !c[6]);
      chk(comp, c[4:2]); chk(cyc, c[4:2] * 5);
      rchk(8'h5c, c & 8'h5c);
    end
    $display("threshold test done");
    // trip event raises irq only while unmasked and uncleared
    @(posedge clk) begin tset <= 0; wset <= 8'h10; end
    wreg(8'h5a, 0); repeat (4) @(posedge clk);
    wreg(8'h5d, 8'h07); rchk(8'h5d, 0); chk(irq, 0);
    wreg(8'h5e, 8'h01); @(posedge clk) tset <= 8'h20;
    repeat (4) @(posedge clk);
    #1 chk(irq, 1);
    rchk(8'h5d, 1);
    @(posedge clk) tset <= 0;
    repeat (4) @(posedge clk);
    wreg(8'h5d, 8'h01); rchk(8'h5d, 2); chk(irq, 0);
    // dim start event and live status, with trip and dim both active
    wreg(8'h5e, 8'h05); rchk(8'h5e, 5);
    wreg(8'h5b, 0); wreg(8'h5a, 8'h01); @(posedge clk) tset <= 8'h60;
    repeat (4) @(posedge clk);
    rchk(8'h5f, 3);
    rchk(8'h5d, 7);
    chk(irq, 1);
    $display("interrupt test done");
    wrap_up;
  end
endmodule // tb
